// *** rtl/urx_pkg.sv ***
// Functional notes
// - overrun flag, status bit 3, sets when a character completes into a full FIFO
// - on overrun stored entries stay intact and nothing is pushed
// - break flag, status bit 2, on input low beyond a whole frame
// - one all-zero character is pushed per break, however long it lasts
// - after break, wait for line high and a fresh start bit
// - parity error flag, status bit 1, on parity mismatch with line control; not set for a break frame
// - framing error flag, status bit 0, when the stop bit samples zero; not set for a break frame
// - with FIFO on, break/parity/framing flags follow the FIFO head entry
// - any write to the clear view zeroes all four flags, data ignored; an overrun completing on the same edge still sets bit 3
// - status view is read-only; writes only perform the clear action
// - clear view is write-only; reads there return the status view
// - reserved upper bits read as zero; software leaves them alone
// - status shows errors of the last read character; overrun shows at once
// - reset clears all four error flags
package urx_pkg;
    // register byte offsets
    localparam int unsigned   ADR_W      = 12;
    localparam logic [11:0]   OFF_DATA   = 12'h000;
    localparam logic [11:0]   OFF_STAT   = 12'h004;
    localparam logic [11:0]   OFF_DIV    = 12'h024;
    localparam logic [11:0]   OFF_LCR    = 12'h02c;
    localparam logic [11:0]   OFF_IMASK  = 12'h038;
    localparam logic [11:0]   OFF_ISTAT  = 12'h03c;
    // error bit positions, shared by status view and interrupt status
    localparam int unsigned   ERR_FE     = 0;
    localparam int unsigned   ERR_PE     = 1;
    localparam int unsigned   ERR_BE     = 2;
    localparam int unsigned   ERR_OE     = 3;
    localparam int unsigned   ERR_W      = 4;
    localparam int unsigned   IRQ_RX     = 4;
    localparam int unsigned   IRQ_W      = 5;
    // data register: received byte low, error bits from this position up
    localparam int unsigned   DR_ERR_LSB = 8;
    // line control fields
    localparam int unsigned   LCR_PEN    = 1;
    localparam int unsigned   LCR_EPS    = 2;
    localparam int unsigned   LCR_FEN    = 4;
    localparam int unsigned   LCR_WLEN   = 5;
    localparam int unsigned   LCR_SPS    = 7;
    localparam logic [7:0]    LCR_RST    = 8'h00;
    localparam logic [15:0]   DIV_RST    = 16'h0000;
    localparam logic [IRQ_W-1:0] IMASK_RST = 5'h00;
    // 16x oversampling: start checked mid bit, later bits a full bit on
    localparam logic [3:0]    OVS_MID    = 4'h7;
    localparam logic [3:0]    OVS_LAST   = 4'hf;
    localparam logic [2:0]    WLEN_BASE  = 3'h4;
    // fifo entry: {break, parity, framing, data}
    localparam int unsigned   ENT_W      = 11;
    localparam int unsigned   RX_DEPTH   = 16;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b010,
        ST_PAR   = 3'b011,
        ST_STOP  = 3'b100,
        ST_BRK   = 3'b101
    } urx_state_e;
endpackage

// *** rtl/urx_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for the asynchronous receive pin
module urx_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta;

    // meta feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta     <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// *** rtl/urx_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
// receive fifo; depth must be a power of two
module urx_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     push,
    input  wire logic [WIDTH-1:0]         wdata,
    input  wire logic                     pop,
    output logic      [WIDTH-1:0]         rdata,
    output logic                          full,
    output logic                          empty
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      cnt;
    logic             do_push;
    logic             do_pop;

    // a push into a full fifo is dropped here as well
    assign do_push = push & ~full;
    assign do_pop  = pop & ~empty;
    assign full    = (cnt == FULL_CNT);
    assign empty   = (cnt == '0);
    assign rdata   = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= wdata;
        end
    end

    // pointers and fill count
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt    <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(do_push);
            rd_ptr <= rd_ptr + AW'(do_pop);
            cnt    <= cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule
`default_nettype wire

// *** rtl/urx_err_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// serial receiver with error status, error clear and wishbone registers
module urx_err_top #(
    parameter int unsigned DEPTH = urx_pkg::RX_DEPTH
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_in,
    output logic             irq
);
    logic                          rx_s;
    logic [7:0]                    lcr;
    logic [15:0]                   baud_div;
    logic [15:0]                   div_cnt;
    logic                          os_tick;
    urx_pkg::urx_state_e           state;
    logic [3:0]                    ph;
    logic [2:0]                    bit_idx;
    logic [7:0]                    shreg;
    logic                          par_bit;
    logic [urx_pkg::ERR_W-1:0]     err;
    logic [urx_pkg::IRQ_W-1:0]     istat;
    logic [urx_pkg::IRQ_W-1:0]     imask;
    logic [urx_pkg::ENT_W-1:0]     head;
    logic                          f_full;
    logic                          f_empty;

    urx_sync #(
        .RST_VAL (1'b1)
    ) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .async_in (rx_in),
        .sync_out (rx_s)
    );

    // line control decode
    wire       pen      = lcr[urx_pkg::LCR_PEN];
    wire       eps      = lcr[urx_pkg::LCR_EPS];
    wire       fen      = lcr[urx_pkg::LCR_FEN];
    wire       sps      = lcr[urx_pkg::LCR_SPS];
    wire [2:0] wlen_top = urx_pkg::WLEN_BASE + {1'b0, lcr[urx_pkg::LCR_WLEN +: 2]};

    // oversample enable: divisor zero behaves as one
    wire [15:0] div_m1 = (baud_div == '0) ? '0 : baud_div - 16'h0001;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_cnt <= '0;
            os_tick <= 1'b0;
        end else begin
            os_tick <= (div_cnt == '0);
            div_cnt <= (div_cnt == '0) ? div_m1 : div_cnt - 16'h0001;
        end
    end

    // sample points and frame completion
    wire at_mid    = os_tick && (ph == urx_pkg::OVS_MID);
    wire at_last   = os_tick && (ph == urx_pkg::OVS_LAST);
    wire char_done = at_last && (state == urx_pkg::ST_STOP);
    // even parity bit equals xor of data; stick parity is the inverse of eps
    wire par_exp   = sps ? ~eps : (eps ? ^shreg : ~^shreg);
    // every bit of the frame low, stop included: a break, not a character
    wire brk_now   = char_done && !rx_s && (shreg == '0) && !(pen && par_bit);
    wire fe_now    = char_done && !rx_s && !brk_now;
    wire pe_now    = char_done && !brk_now && pen && (par_bit != par_exp);
    // FIFO off leaves a single holding entry
    wire rx_full   = fen ? f_full : ~f_empty;
    wire ovr_now   = char_done && rx_full;
    wire push      = char_done && !rx_full;
    // a break entry carries a zero byte and only the break bit
    wire [urx_pkg::ENT_W-1:0] push_ent = {brk_now, pe_now, fe_now, brk_now ? 8'h00 : shreg};

    // receive state machine; bit states advanced on oversample ticks, idle and break exits on the line level alone
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state   <= urx_pkg::ST_IDLE;
            ph      <= '0;
            bit_idx <= '0;
            shreg   <= '0;
            par_bit <= 1'b0;
        end else begin
            if (os_tick) begin
                ph <= ph + 4'h1;
            end
            case (state)
                urx_pkg::ST_IDLE: begin
                    ph <= '0;
                    if (!rx_s) begin
                        state <= urx_pkg::ST_START;
                    end
                end
                urx_pkg::ST_START: begin
                    if (at_mid) begin
                        // a glitch shorter than half a bit is ignored
                        state   <= rx_s ? urx_pkg::ST_IDLE : urx_pkg::ST_DATA;
                        ph      <= '0;
                        bit_idx <= '0;
                        shreg   <= '0;
                    end
                end
                urx_pkg::ST_DATA: begin
                    if (at_last) begin
                        shreg[bit_idx] <= rx_s;
                        bit_idx        <= bit_idx + 3'h1;
                        if (bit_idx == wlen_top) begin
                            state <= pen ? urx_pkg::ST_PAR : urx_pkg::ST_STOP;
                        end
                    end
                end
                urx_pkg::ST_PAR: begin
                    if (at_last) begin
                        par_bit <= rx_s;
                        state   <= urx_pkg::ST_STOP;
                    end
                end
                urx_pkg::ST_STOP: begin
                    if (at_last) begin
                        state <= brk_now ? urx_pkg::ST_BRK : urx_pkg::ST_IDLE;
                    end
                end
                urx_pkg::ST_BRK: begin
                    // hold off until the line marks again
                    if (rx_s) begin
                        state <= urx_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= urx_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // wishbone decode; answer always one cycle after the request
    wire req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr       = req && wb_we_i;
    wire rd       = req && !wb_we_i;
    wire hit_data = (wb_adr_i == urx_pkg::OFF_DATA);
    wire hit_stat = (wb_adr_i == urx_pkg::OFF_STAT);
    wire hit_div  = (wb_adr_i == urx_pkg::OFF_DIV);
    wire hit_lcr  = (wb_adr_i == urx_pkg::OFF_LCR);
    wire hit_imsk = (wb_adr_i == urx_pkg::OFF_IMASK);
    wire hit_ist  = (wb_adr_i == urx_pkg::OFF_ISTAT);
    wire pop      = rd && hit_data && !f_empty;
    // any write at the shared location clears, whatever lanes or data
    wire err_clr  = wr && hit_stat;

    // each entry carries its own error bits so the flags travel with the character
    urx_fifo #(
        .WIDTH (urx_pkg::ENT_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .push     (push),
        .wdata    (push_ent),
        .pop      (pop),
        .rdata    (head),
        .full     (f_full),
        .empty    (f_empty)
    );

    // error flags: read character's errors latch on pop, overrun at once
    wire [urx_pkg::ERR_W-1:0] err_set = {ovr_now, pop ? head[urx_pkg::DR_ERR_LSB +: 3] : 3'h0};
    wire [urx_pkg::ERR_W-1:0] next_err = (err_clr ? '0 : err) | err_set;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            err <= '0;
        end else begin
            err <= next_err;
        end
    end

    // interrupt events and software write-one-to-clear
    wire [urx_pkg::IRQ_W-1:0] irq_ev  = {push, ovr_now, brk_now, pe_now, fe_now};
    wire [urx_pkg::IRQ_W-1:0] irq_w1c = (wr && hit_ist) ? wb_dat_i[urx_pkg::IRQ_W-1:0] : '0;
    wire [urx_pkg::IRQ_W-1:0] next_istat = (istat & ~irq_w1c) | irq_ev;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            istat <= '0;
            irq   <= 1'b0;
        end else begin
            istat <= next_istat;
            // one cycle behind the status bit, traded for a flop output
            irq   <= |(istat & imask);
        end
    end

    // software-written control registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lcr      <= urx_pkg::LCR_RST;
            baud_div <= urx_pkg::DIV_RST;
            imask    <= urx_pkg::IMASK_RST;
        end else begin
            if (wr && hit_lcr && wb_sel_i[0]) begin
                lcr <= wb_dat_i[7:0];
            end
            if (wr && hit_div && wb_sel_i[0]) begin
                baud_div[7:0] <= wb_dat_i[7:0];
            end
            if (wr && hit_div && wb_sel_i[1]) begin
                baud_div[15:8] <= wb_dat_i[15:8];
            end
            if (wr && hit_imsk && wb_sel_i[0]) begin
                imask <= wb_dat_i[urx_pkg::IRQ_W-1:0];
            end
        end
    end

    // read mux; reserved and unmapped bits read as zero
    wire [31:0] rd_data = {20'h00000, err[urx_pkg::ERR_OE], head};
    wire [31:0] rd_stat = {28'h0000000, err};
    wire [31:0] rd_mux  = hit_data ? rd_data :
                          hit_stat ? rd_stat :
                          hit_div  ? {16'h0000, baud_div} :
                          hit_lcr  ? {24'h000000, lcr} :
                          hit_imsk ? {27'h0000000, imask} :
                          hit_ist  ? {27'h0000000, istat} : 32'h00000000;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    // all checks run on the core clock; all but the two reset checks sleep while reset is held
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // receive-path checks
    ovr_flag_set_a: assert property (ovr_now |=> err[urx_pkg::ERR_OE])
        else $error("overrun not flagged");
    ovr_no_push_a: assert property (ovr_now |-> !push)
        else $error("push into full fifo");
    brk_entry_a: assert property (brk_now && push |-> push_ent == 11'h400)
        else $error("break entry wrong");
    brk_one_char_a: assert property (state == urx_pkg::ST_BRK |-> !push)
        else $error("extra char during break");
    brk_wait_high_a: assert property (state == urx_pkg::ST_BRK && !rx_s |=>
        state == urx_pkg::ST_BRK)
        else $error("left break while low");
    brk_exit_a: assert property (state == urx_pkg::ST_BRK |=>
        state == urx_pkg::ST_BRK || state == urx_pkg::ST_IDLE)
        else $error("break left to a wrong state");
    par_err_a: assert property (pe_now && push |-> push_ent[urx_pkg::DR_ERR_LSB + 1])
        else $error("parity error not stored");
    stick_par_a: assert property (char_done && pen && sps && !brk_now |->
        (par_bit == eps) == pe_now)
        else $error("stick parity misjudged");
    frm_err_a: assert property (char_done && !rx_s && (shreg != 8'h00) |->
        push_ent[urx_pkg::DR_ERR_LSB])
        else $error("framing error missed");
    ovr_keep_a: assert property (ovr_now && fen && !pop |=> f_full)
        else $error("overrun disturbed the fifo");

    // status-flag and register checks
    head_flag_a: assert property (pop && head[urx_pkg::DR_ERR_LSB] |=>
        err[urx_pkg::ERR_FE])
        else $error("head framing not shown");
    pop_par_a: assert property (pop && head[urx_pkg::DR_ERR_LSB + 1] |=>
        err[urx_pkg::ERR_PE])
        else $error("read parity error not shown");
    pop_brk_a: assert property (pop && head[urx_pkg::DR_ERR_LSB + 2] |=>
        err[urx_pkg::ERR_BE])
        else $error("read break not shown");
    flag_sticky_a: assert property (!err_clr |=>
        (err & $past(err)) == $past(err))
        else $error("flag fell without a clear");
    clr_all_a: assert property (err_clr && !ovr_now && !pop |=> err == '0)
        else $error("clear left a flag");
    stat_read_a: assert property (rd && hit_stat ##1 wb_ack_o |->
        wb_dat_o == {28'h0000000, $past(err)})
        else $error("status read mismatch");
    set_wins_a: assert property (err_clr && ovr_now |=> err[urx_pkg::ERR_OE])
        else $error("clear beat event");
    rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> err == '0)
        else $error("reset left a flag");
    rst_outputs_a: assert property (disable iff (1'b0) sys_rst |=>
        istat == '0 && !wb_ack_o && !irq)
        else $error("reset left an output high");

    cov_overrun_c: cover property (ovr_now);
    cov_set_wins_c: cover property (err_clr && ovr_now);
    cov_break_c: cover property (brk_now ##[1:1000] state == urx_pkg::ST_IDLE);
    cov_clear_c: cover property (err != '0 ##1 err_clr ##1 err == '0);
    cov_irq_c: cover property (irq);
endmodule
`default_nettype wire

// *** tb/urx_tx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// remote serial transmitter driving the receive line, idle at the marking level
module urx_tx_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic core_clk,
    output var  logic rx_line
);
    initial rx_line = 1'b1;

    // one level for whole bit times, changed just after a rising edge
    task automatic hold(input logic lvl, input int bits);
        rx_line <= lvl;
        repeat (bits * BIT_CYC) @(posedge core_clk);
    endtask

    // start, eight data bits lsb first, optional parity, one stop, then idle
    task automatic send(input logic [7:0] d, input logic par_on, input logic par,
                        input logic stop);
        @(posedge core_clk);
        hold(1'b0, 1);
        for (int i = 0; i < 8; i++) hold(d[i], 1);
        if (par_on) hold(par, 1);
        hold(stop, 1);
        hold(1'b1, 2); // gap so the next start edge is clean
    endtask

    // line held low well past one frame, then back to marking
    task automatic brk(input int bits);
        @(posedge core_clk);
        hold(1'b0, bits);
        hold(1'b1, 3);
    endtask
endmodule
`default_nettype wire

// *** tb/tb_urx_err_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_urx_err_top;
    // small fifo so overrun is reached after a few frames
    localparam int DEPTH = 4;
    localparam int LIMIT = 40000;
    // start bit to stop sample: 2 sync + 1 detect + 8 to mid + 9 x 16 = 155 edges;
    // the clear request is raised one edge earlier so it is taken on that edge
    localparam int OVR_EDGE = 154;

    logic        core_clk    = 1'b0;
    logic        sys_rst     = 1'b1;
    logic        wb_cyc      = 1'b0;
    logic        wb_stb      = 1'b0;
    logic        wb_we       = 1'b0;
    logic [11:0] wb_adr      = 12'h000;
    logic [3:0]  wb_sel      = 4'hf;
    logic [31:0] wb_dat      = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        rx_line;
    logic        irq;
    int          n_fail      = 0;
    int          check_count = 0;
    int          cycles      = 0;

    urx_err_top #(.DEPTH(DEPTH)) urx_err_top_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_in(rx_line), .irq(irq)
    );
    urx_tx_model #(.BIT_CYC(16)) urx_tx_model_inst (.core_clk(core_clk), .rx_line(rx_line));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hung run counts as a mismatch
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // classic cycle: request stands until ack is sampled high at a rising edge;
    // a hang is caught by the bench timeout
    task automatic wb_xfer(input logic we, input logic [11:0] a, input logic [31:0] wd,
                           output logic [31:0] rd);
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= wd;
        do begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1);
        // read data is taken at the acknowledging edge, then the request drops
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] v;
        wb_xfer(1'b1, a, d, v);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        wb_xfer(1'b0, a, 32'h0, v);
        chk(v, exp);
    endtask

    task automatic t_reset();
        rdc(urx_pkg::OFF_STAT, 32'h0);
        rdc(12'hffc, 32'h0);
        wr(urx_pkg::OFF_DIV, 32'h1);
        rdc(urx_pkg::OFF_DIV, 32'h1);
        chk({31'h0, irq}, 32'h0);
    endtask

    // bad stop on the first of two entries; flags follow the entry read
    task automatic t_frame();
        wr(urx_pkg::OFF_LCR, 32'h70);
        urx_tx_model_inst.send(8'ha5, 1'b0, 1'b0, 1'b0);
        urx_tx_model_inst.send(8'h5a, 1'b0, 1'b0, 1'b1);
        rdc(urx_pkg::OFF_STAT, 32'h0);
        rdc(urx_pkg::OFF_DATA, 32'h1a5);
        rdc(urx_pkg::OFF_STAT, 32'h1);
        rdc(urx_pkg::OFF_DATA, 32'h05a);
        wr(urx_pkg::OFF_STAT, 32'hffff_ffff);
        rdc(urx_pkg::OFF_STAT, 32'h0);
    endtask

    // odd, even, then stick parity, a good and a bad parity bit each
    task automatic t_parity();
        logic [7:0] d;
        logic       good;
        d = 8'h3c;
        for (int e = 0; e < 3; e++) begin
            // stick parity with even select expects a zero parity bit
            good = (e == 2) ? 1'b0 : (e == 1) ? ^d : ~^d;
            wr(urx_pkg::OFF_LCR, (e == 2) ? 32'hf6 : 32'h72 | (e << 2));
            urx_tx_model_inst.send(d, 1'b1, good, 1'b1);
            urx_tx_model_inst.send(d, 1'b1, ~good, 1'b1);
            rdc(urx_pkg::OFF_DATA, 32'h03c);
            rdc(urx_pkg::OFF_DATA, 32'h23c);
            rdc(urx_pkg::OFF_STAT, 32'h2);
            wr(urx_pkg::OFF_STAT, 32'h0);
        end
    endtask

    // long break gives one zero entry, then a normal character follows
    task automatic t_break();
        wr(urx_pkg::OFF_LCR, 32'h70);
        urx_tx_model_inst.brk(24);
        urx_tx_model_inst.send(8'h5a, 1'b0, 1'b0, 1'b1);
        rdc(urx_pkg::OFF_DATA, 32'h400);
        rdc(urx_pkg::OFF_STAT, 32'h4);
        rdc(urx_pkg::OFF_DATA, 32'h05a);
        wr(urx_pkg::OFF_STAT, 32'h0);
    endtask

    // one frame more than the fifo holds, then an overrun that meets a clear
    task automatic t_over();
        logic [31:0] v;
        for (int i = 0; i <= DEPTH; i++) begin
            urx_tx_model_inst.send(8'(8'h10 + i), 1'b0, 1'b0, 1'b1);
        end
        rdc(urx_pkg::OFF_STAT, 32'h8);
        wr(urx_pkg::OFF_STAT, 32'h0);
        rdc(urx_pkg::OFF_STAT, 32'h0);
        // the clear is taken on the very edge the next stop bit completes
        fork
            urx_tx_model_inst.send(8'h15, 1'b0, 1'b0, 1'b1);
            begin
                repeat (OVR_EDGE) @(posedge core_clk);
                wr(urx_pkg::OFF_STAT, 32'h0);
            end
        join
        rdc(urx_pkg::OFF_STAT, 32'h8);
        for (int i = 0; i < DEPTH; i++) begin
            wb_xfer(1'b0, urx_pkg::OFF_DATA, 32'h0, v);
            chk({24'h0, v[7:0]}, 32'h10 + i);
        end
        wr(urx_pkg::OFF_STAT, 32'h0);
        rdc(urx_pkg::OFF_STAT, 32'h0);
        urx_tx_model_inst.send(8'h20, 1'b0, 1'b0, 1'b1);
        rdc(urx_pkg::OFF_DATA, 32'h020);
    endtask

    // char-stored interrupt: raised, masked, unmasked, cleared
    task automatic t_irq();
        wr(urx_pkg::OFF_ISTAT, 32'h1f);
        wr(urx_pkg::OFF_IMASK, 32'h10);
        urx_tx_model_inst.send(8'h33, 1'b0, 1'b0, 1'b1);
        repeat (3) @(negedge core_clk);
        chk({31'h0, irq}, 32'h1);
        rdc(urx_pkg::OFF_DATA, 32'h033);
        wr(urx_pkg::OFF_IMASK, 32'h0);
        repeat (3) @(negedge core_clk);
        chk({31'h0, irq}, 32'h0);
        wr(urx_pkg::OFF_IMASK, 32'h10);
        repeat (3) @(negedge core_clk);
        chk({31'h0, irq}, 32'h1);
        wr(urx_pkg::OFF_ISTAT, 32'h10);
        repeat (3) @(negedge core_clk);
        chk({31'h0, irq}, 32'h0);
    endtask

    // no fifo, five data bits: the holding entry overruns on a second character
    task automatic t_nofifo();
        wr(urx_pkg::OFF_LCR, 32'h00);
        // upper three data bits high act as idle after the short frame
        urx_tx_model_inst.send(8'he1, 1'b0, 1'b0, 1'b1);
        urx_tx_model_inst.send(8'he2, 1'b0, 1'b0, 1'b1);
        rdc(urx_pkg::OFF_STAT, 32'h8);
        rdc(urx_pkg::OFF_DATA, 32'h801);
        wr(urx_pkg::OFF_STAT, 32'h0);
        rdc(urx_pkg::OFF_STAT, 32'h0);
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_frame();
        t_parity();
        t_break();
        t_over();
        t_irq();
        t_nofifo();
        give_verdict();
    end
endmodule
`default_nettype wire
